// ### hw/link_ctrl_pkg.sv
// Shared constants and types for the serial link mode and control block.
package link_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_ENC8,
        MODE_RAW10,
        MODE_ENC10,
        MODE_RAW12
    } path_mode_t;

    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;

    // Control register field positions.
    localparam int CTRL_RESET_REQ = 0;
    localparam int CTRL_INPUT_SEL = 1;

    // Interrupt event bit positions.
    localparam int EV_FAULT_SET = 0;
    localparam int EV_FAULT_CLR = 1;
    localparam int EV_BAD_CONFIG = 2;
    localparam int EV_RESET_DONE = 3;
    localparam int EV_WIDTH = 4;

    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;

    // Reset pulse timing, in reference clock periods and in pclk cycles.
    localparam int REF_PERIOD_NS = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_RESET_REF_PERIODS = 1;
    localparam int MIN_RESET_CYCLES =
        (MIN_RESET_REF_PERIODS * REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Length of the internal logic reset pulse issued by software request.
    localparam int SW_RESET_CYCLES = 4;
    localparam int CNT_W = 4;
endpackage

// ### hw/mode_decode.sv
// Data path mode decode from the character width and coder bypass straps.
`timescale 1ns/100ps
`default_nettype none
module mode_decode
(
    input wire logic char_width_select,
    input wire logic coder_bypass_n,
    input wire logic buffer_bypass_n,
    output var link_ctrl_pkg::path_mode_t path_mode,
    output logic coder_enable,
    output logic config_illegal
);
    // Four combinations map one to one onto the four data path modes.
    always_comb
    begin
        unique case ({char_width_select, coder_bypass_n})
            2'b11: path_mode = link_ctrl_pkg::MODE_ENC8;
            2'b10: path_mode = link_ctrl_pkg::MODE_RAW10;
            2'b01: path_mode = link_ctrl_pkg::MODE_ENC10;
            2'b00: path_mode = link_ctrl_pkg::MODE_RAW12;
        endcase
    end

    // A low bypass strap disables encoder and decoder together.
    assign coder_enable = coder_bypass_n;

    // Encoded 10-bit width with buffers bypassed is flagged, not silently used.
    assign config_illegal = !buffer_bypass_n && coder_bypass_n && !char_width_select;
endmodule
`default_nettype wire

// ### hw/reset_filter.sv
// Two-pin global logic reset qualifier with minimum width check.
`timescale 1ns/100ps
`default_nettype none
module reset_filter
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] logic_reset_pair_n,
    input wire logic sw_reset,
    output logic logic_reset,
    output logic reset_done
);
    logic [link_ctrl_pkg::CNT_W-1:0] low_cnt_ff;
    logic [link_ctrl_pkg::CNT_W-1:0] sw_cnt_ff;
    logic active_ff;

    // Count pclk cycles with both pins low; one pin alone never resets.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt_ff <= '0;
        else if (logic_reset_pair_n != 2'b00)
            low_cnt_ff <= '0;
        else if (low_cnt_ff != {link_ctrl_pkg::CNT_W{1'b1}})
            low_cnt_ff <= low_cnt_ff + 1'b1;
    end

    // Software requested reset stretches for a fixed number of cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sw_cnt_ff <= '0;
        else if (sw_reset)
            sw_cnt_ff <= link_ctrl_pkg::CNT_W'(link_ctrl_pkg::SW_RESET_CYCLES);
        else if (sw_cnt_ff != '0)
            sw_cnt_ff <= sw_cnt_ff - 1'b1;
    end

    // Pin reset counts once the low pulse has lasted a reference period.
    assign logic_reset = (low_cnt_ff >= link_ctrl_pkg::CNT_W'(link_ctrl_pkg::MIN_RESET_CYCLES))
        || (sw_cnt_ff != '0);

    // One-cycle pulse on the release of internal reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_ff <= 1'b0;
        else
            active_ff <= logic_reset;
    end
    assign reset_done = active_ff && !logic_reset;
endmodule
`default_nettype wire

// ### hw/serial_link_mode_control.sv
// Top level of the serial link mode, routing, fault and reset control block.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module serial_link_mode_control
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic char_width_select,
    input wire logic coder_bypass_n,
    input wire logic buffer_bypass_n,
    input wire logic [1:0] logic_reset_pair_n,
    input wire logic factory_diag_n,
    input wire logic serial_input_select,
    input wire logic [1:0] loopback_select,
    input wire logic carrier_present,
    input wire logic receive_character_clock,
    input wire logic serial_in_first,
    input wire logic serial_in_second,
    input wire logic serial_in_suitable,
    input wire logic tx_serial,
    output logic serial_out_first,
    output logic serial_out_second,
    output logic rx_recovery_in,
    output logic link_fault_n,
    output var link_ctrl_pkg::path_mode_t path_mode,
    output logic coder_enable,
    output logic buffer_enable,
    output logic diag_mode,
    output logic logic_reset
);
    logic [31:0] ctrl_ff;
    logic [link_ctrl_pkg::EV_WIDTH-1:0] irq_stat_ff;
    logic [link_ctrl_pkg::EV_WIDTH-1:0] irq_mask_ff;
    logic [link_ctrl_pkg::EV_WIDTH-1:0] events;
    logic [1:0] receive_character_clock_sync_ff;
    logic receive_character_clock_prev_ff;
    logic receive_character_clock_rise;
    logic fault_ff;
    logic fault_prev_ff;
    logic config_illegal;
    logic illegal_prev_ff;
    logic reset_done;
    logic sw_reset;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic selected_in;

    mode_decode u_mode
    (
        .char_width_select(char_width_select),
        .coder_bypass_n(coder_bypass_n),
        .buffer_bypass_n(buffer_bypass_n),
        .path_mode(path_mode),
        .coder_enable(coder_enable),
        .config_illegal(config_illegal)
    );

    reset_filter u_reset
    (
        .pclk(pclk),
        .presetn(presetn),
        .logic_reset_pair_n(logic_reset_pair_n),
        .sw_reset(sw_reset),
        .logic_reset(logic_reset),
        .reset_done(reset_done)
    );

    // APB decode; zero wait states, so pready is tied high in the access phase.
    assign addr_ok = (paddr == link_ctrl_pkg::OFF_CTRL) || (paddr == link_ctrl_pkg::OFF_STATUS)
        || (paddr == link_ctrl_pkg::OFF_IRQ_STAT) || (paddr == link_ctrl_pkg::OFF_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && penable && !pwrite && addr_ok;
    assign sw_reset = wr_en && (paddr == link_ctrl_pkg::OFF_CTRL)
        && pwdata[link_ctrl_pkg::CTRL_RESET_REQ];

    // Buffers enabled unless the bypass strap is low.
    assign buffer_enable = buffer_bypass_n;
    // The diagnostic pin is only reported; normal logic ignores it.
    assign diag_mode = !factory_diag_n;

    // Control register; the reset request bit is self clearing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= link_ctrl_pkg::CTRL_RESET;
        else if (wr_en && paddr == link_ctrl_pkg::OFF_CTRL)
            ctrl_ff <= {30'h0000_0000, pwdata[link_ctrl_pkg::CTRL_INPUT_SEL], 1'b0};
    end

    // Mask register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_ff <= link_ctrl_pkg::MASK_RESET;
        else if (wr_en && paddr == link_ctrl_pkg::OFF_IRQ_MASK)
            irq_mask_ff <= pwdata[link_ctrl_pkg::EV_WIDTH-1:0];
    end

    // The pin select and the software bit must agree to pick the first input.
    // Gating both keeps the strap authoritative while letting software override to second.
    assign selected_in = (serial_input_select && ctrl_ff[link_ctrl_pkg::CTRL_INPUT_SEL])
        ? serial_in_first : serial_in_second;
    assign rx_recovery_in = (loopback_select == 2'b00) ? selected_in : tx_serial;

    // Output routing: 00 normal, 01 loopthrough on the second output,
    // 10 and 11 diagnostic loopback with outputs parked low.
    always_comb
    begin
        unique case (loopback_select)
            2'b00:
            begin
                serial_out_first = tx_serial;
                serial_out_second = tx_serial;
            end
            2'b01:
            begin
                serial_out_first = tx_serial;
                serial_out_second = selected_in;
            end
            2'b10, 2'b11:
            begin
                serial_out_first = 1'b0;
                serial_out_second = 1'b0;
            end
        endcase
    end

    // Receive character clock is sampled into pclk; only the second stage is used.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            receive_character_clock_sync_ff <= 2'b00;
            receive_character_clock_prev_ff <= 1'b0;
        end
        else
        begin
            receive_character_clock_sync_ff <= {receive_character_clock_sync_ff[0], receive_character_clock};
            receive_character_clock_prev_ff <= receive_character_clock_sync_ff[1];
        end
    end
    assign receive_character_clock_rise = receive_character_clock_sync_ff[1] && !receive_character_clock_prev_ff;

    // Fault is forced by logic reset and otherwise updated only on a receive clock rise, so it follows that clock.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_ff <= 1'b1;
        else if (logic_reset)
            fault_ff <= 1'b1;
        else if (receive_character_clock_rise)
            fault_ff <= !carrier_present || !serial_in_suitable;
    end
    assign link_fault_n = !fault_ff;

    // Edge memories for event generation.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_prev_ff <= 1'b1;
            illegal_prev_ff <= 1'b0;
        end
        else
        begin
            fault_prev_ff <= fault_ff;
            illegal_prev_ff <= config_illegal;
        end
    end

    // Events; a forbidden strap combination raises a sticky flag for software.
    assign events[link_ctrl_pkg::EV_FAULT_SET] = fault_ff && !fault_prev_ff;
    assign events[link_ctrl_pkg::EV_FAULT_CLR] = !fault_ff && fault_prev_ff;
    assign events[link_ctrl_pkg::EV_BAD_CONFIG] = config_illegal && !illegal_prev_ff;
    assign events[link_ctrl_pkg::EV_RESET_DONE] = reset_done;

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_ff <= '0;
        else if (wr_en && paddr == link_ctrl_pkg::OFF_IRQ_STAT)
            irq_stat_ff <= (irq_stat_ff & ~pwdata[link_ctrl_pkg::EV_WIDTH-1:0]) | events;
        else
            irq_stat_ff <= irq_stat_ff | events;
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read data register; status shows live pins and decoded mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                link_ctrl_pkg::OFF_CTRL: prdata <= ctrl_ff;
                link_ctrl_pkg::OFF_STATUS:
                    prdata <= {24'h00_0000, diag_mode, logic_reset, config_illegal,
                        buffer_enable, coder_enable, link_fault_n, path_mode};
                link_ctrl_pkg::OFF_IRQ_STAT: prdata <= {28'h000_0000, irq_stat_ff};
                link_ctrl_pkg::OFF_IRQ_MASK: prdata <= {28'h000_0000, irq_mask_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Carrier loss reaches the fault output one pclk after the synced receive clock edge.
    carrier_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        (receive_character_clock_rise && !carrier_present && !logic_reset) |=> !link_fault_n)
        else $error("carrier loss did not raise fault");
    fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!receive_character_clock_rise && !logic_reset) |=> $stable(link_fault_n))
        else $error("fault changed without receive clock");
    unsuitable_a: assert property (@(posedge pclk) disable iff (!presetn)
        (receive_character_clock_rise && !serial_in_suitable && !logic_reset) |=> !link_fault_n)
        else $error("unsuitable input not reported");
    fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (receive_character_clock_rise && carrier_present && serial_in_suitable && !logic_reset) |=> link_fault_n)
        else $error("fault stuck with good input");
    // A set event must survive a clear written in the same cycle.
    fault_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fault_ff && !fault_prev_ff) |=> irq_stat_ff[link_ctrl_pkg::EV_FAULT_SET])
        else $error("fault event lost");

    // Internal reset withdraws the link, so no data is trusted while it runs.
    reset_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        logic_reset |=> !link_fault_n)
        else $error("fault not forced during reset");
    sw_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> logic_reset [*4])
        else $error("software reset too short");
    pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (logic_reset_pair_n == 2'b00) [*2] |-> logic_reset)
        else $error("held reset pins ignored");

    // Strap decode; the illegal bypass mix is still decoded but also flagged.
    mode_enc8_a: assert property (@(posedge pclk) disable iff (!presetn)
        (char_width_select && coder_bypass_n) |-> path_mode == link_ctrl_pkg::MODE_ENC8)
        else $error("wrong 8-bit mode");
    mode_raw10_a: assert property (@(posedge pclk) disable iff (!presetn)
        (char_width_select && !coder_bypass_n) |-> path_mode == link_ctrl_pkg::MODE_RAW10)
        else $error("wrong raw 10 mode");
    mode_enc10_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!char_width_select && coder_bypass_n) |-> path_mode == link_ctrl_pkg::MODE_ENC10)
        else $error("wrong 10-bit mode");
    mode_raw12_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!char_width_select && !coder_bypass_n) |-> path_mode == link_ctrl_pkg::MODE_RAW12)
        else $error("wrong raw 12 mode");
    raw_no_coder_a: assert property (@(posedge pclk) disable iff (!presetn)
        (path_mode == link_ctrl_pkg::MODE_RAW10 || path_mode == link_ctrl_pkg::MODE_RAW12)
        |-> !coder_enable)
        else $error("coder left on in raw mode");
    buffer_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        !buffer_bypass_n |-> !buffer_enable)
        else $error("buffers left in path");
    bad_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(config_illegal) |=> irq_stat_ff[link_ctrl_pkg::EV_BAD_CONFIG])
        else $error("bad config not flagged");

    // Routing; exactly one serial input reaches recovery in normal routing 00; 01, 10 and 11 feed it tx_serial.
    recovery_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loopback_select == 2'b00 && !serial_input_select)
        |-> rx_recovery_in == serial_in_second)
        else $error("wrong recovery input");
    recovery_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loopback_select == 2'b00 && serial_input_select && ctrl_ff[link_ctrl_pkg::CTRL_INPUT_SEL])
        |-> rx_recovery_in == serial_in_first)
        else $error("first input not selected");
    loopthru_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loopback_select == 2'b01) |-> serial_out_second == selected_in)
        else $error("loopthrough not routed");
    loopthru_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loopback_select == 2'b01) |-> serial_out_first == tx_serial)
        else $error("first output lost in loopthrough");
    diag_park_a: assert property (@(posedge pclk) disable iff (!presetn)
        loopback_select[1] |-> (!serial_out_first && !serial_out_second))
        else $error("outputs not parked in loopback");

    // Main scenarios that the bench is expected to reach.
    cov_fault: cover property (@(posedge pclk) disable iff (!presetn) $fell(link_fault_n));
    cov_reset: cover property (@(posedge pclk) disable iff (!presetn) reset_done);
    cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cov_bad_cfg: cover property (@(posedge pclk) disable iff (!presetn) $rose(config_illegal));
    cov_route: cover property (@(posedge pclk) disable iff (!presetn) loopback_select[0]);
endmodule
`default_nettype wire

// ### tb/strap_host.sv
// Board-side model that drives the static straps and the two-pin reset.
`timescale 1ns/100ps
`default_nettype none
module strap_host
(
    input wire logic pclk,
    output logic char_width_select,
    output logic coder_bypass_n,
    output logic buffer_bypass_n,
    output logic [1:0] logic_reset_pair_n,
    output logic factory_diag_n,
    output logic serial_input_select,
    output logic [1:0] loopback_select,
    output logic carrier_present
);
    // Straps start in the plain encoded 8-bit setup with carrier present.
    initial
    begin
        char_width_select = 1'b1;
        coder_bypass_n = 1'b1;
        buffer_bypass_n = 1'b1;
        logic_reset_pair_n = 2'h3;
        factory_diag_n = 1'b1;
        serial_input_select = 1'b1;
        loopback_select = 2'h0;
        carrier_present = 1'b1;
    end

    // Both pins move in one assignment so they can never skew apart.
    task automatic pulse_reset(input int n);
        @(posedge pclk);
        logic_reset_pair_n <= 2'h0;
        repeat (n) @(posedge pclk);
        logic_reset_pair_n <= 2'h3;
    endtask

    // Width is forced high when bypassed buffers meet the encoder.
    task automatic set_mode(input logic cw, input logic cb, input logic bb);
        @(posedge pclk);
        char_width_select <= cw | (cb & ~bb);
        coder_bypass_n <= cb;
        buffer_bypass_n <= bb;
        pulse_reset(1);
    endtask

    // Route and carrier changes are launched just after an edge.
    task automatic set_route(input logic sel, input logic [1:0] lb);
        @(posedge pclk);
        serial_input_select <= sel;
        loopback_select <= lb;
    endtask

    task automatic set_carrier(input logic c);
        @(posedge pclk);
        carrier_present <= c;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the serial link mode control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [11:0] A_CTRL = link_ctrl_pkg::OFF_CTRL;
    localparam logic [11:0] A_STAT = link_ctrl_pkg::OFF_STATUS;
    localparam logic [11:0] A_IRQ = link_ctrl_pkg::OFF_IRQ_STAT;
    localparam logic [11:0] A_MASK = link_ctrl_pkg::OFF_IRQ_MASK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic char_width_select, coder_bypass_n, buffer_bypass_n, factory_diag_n;
    logic serial_input_select, carrier_present, serial_in_first, serial_in_second;
    logic serial_in_suitable, tx_serial, serial_out_first, serial_out_second;
    logic rx_recovery_in, link_fault_n, coder_enable, buffer_enable, diag_mode;
    logic logic_reset;
    logic [1:0] logic_reset_pair_n, loopback_select, rx_div;
    link_ctrl_pkg::path_mode_t path_mode;
    int err_total = 0;
    int num_checks = 0;

    serial_link_mode_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .char_width_select, .coder_bypass_n,
        .buffer_bypass_n, .logic_reset_pair_n, .factory_diag_n, .serial_input_select,
        .loopback_select, .carrier_present, .receive_character_clock(rx_div[1]),
        .serial_in_first, .serial_in_second, .serial_in_suitable, .tx_serial,
        .serial_out_first, .serial_out_second, .rx_recovery_in, .link_fault_n, .path_mode,
        .coder_enable, .buffer_enable, .diag_mode, .logic_reset);
    strap_host i_host (.pclk, .char_width_select, .coder_bypass_n, .buffer_bypass_n,
        .logic_reset_pair_n, .factory_diag_n, .serial_input_select, .loopback_select,
        .carrier_present);

    // Free-running bus clock and a slower character clock derived from it.
    always #4 pclk = ~pclk;
    always @(posedge pclk) rx_div <= rx_div + 2'h1;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; only the watchdog ends a wait on pready, so a stuck slave fails.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the sequence needs.
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test();
    end

    // Main sequence.
    initial
    begin
        logic cw, cb, bb, selv;
        int cnt;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rx_div = 2'h0;
        serial_in_first = 1'b0;
        serial_in_second = 1'b0;
        serial_in_suitable = 1'b1;
        tx_serial = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        chk("ctrl", rd, link_ctrl_pkg::CTRL_RESET);
        apb(1'b0, A_MASK, 32'h0);
        chk("mask", rd, {28'h0, link_ctrl_pkg::MASK_RESET});
        chk("diag", {31'h0, diag_mode}, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk("wr_err", {31'h0, perr}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("rd_err", {rd[30:0], perr}, 32'h1);
        // Walk all four data path modes, once with the buffers bypassed.
        for (int m = 0; m < 4; m++)
        begin
            cw = ~m[1];
            cb = ~m[0];
            bb = (m != 0);
            i_host.set_mode(cw, cb, bb);
            repeat (8) @(posedge pclk);
            apb(1'b0, A_STAT, 32'h0);
            chk("mode", {30'h0, path_mode}, 32'(m));
            chk("status", rd & 32'h3B, {26'h0, 1'b0, bb, cb, 1'b0, 2'(m)});
            chk("enables", {30'h0, buffer_enable, coder_enable}, {30'h0, bb, cb});
        end
        // Break the bypass restriction once on purpose: it must be flagged, not hidden.
        @(posedge pclk);
        i_host.char_width_select <= 1'b0;
        i_host.coder_bypass_n <= 1'b1;
        i_host.buffer_bypass_n <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(1'b0, A_STAT, 32'h0);
        chk("bad_stat", rd & 32'h23, 32'h22);
        apb(1'b0, A_IRQ, 32'h0);
        chk("bad_flag", rd & 32'h4, 32'h4);
        i_host.set_mode(1'b1, 1'b1, 1'b1);
        apb(1'b1, A_CTRL, 32'h2);
        // Every input pattern through every route and both input selections.
        for (int s = 0; s < 2; s++)
            for (int lb = 0; lb < 4; lb++)
                for (int p = 0; p < 8; p++)
                begin
                    i_host.set_route(s[0], lb[1:0]);
                    serial_in_first <= p[0];
                    serial_in_second <= p[1];
                    tx_serial <= p[2];
                    @(posedge pclk);
                    selv = s[0] ? p[0] : p[1];
                    if (lb == 0)
                        chk("route0", {serial_out_first, serial_out_second, rx_recovery_in},
                            {29'h0, p[2], p[2], selv});
                    else if (lb == 1)
                        chk("route1", {serial_out_first, serial_out_second},
                            {30'h0, p[2], selv});
                    else
                        chk("route2", {serial_out_first, serial_out_second, rx_recovery_in},
                            {31'h0, p[2]});
                end
        i_host.set_route(1'b1, 2'h0);
        // Fault on carrier loss raises the interrupt only once unmasked.
        apb(1'b1, A_IRQ, 32'hF);
        i_host.set_carrier(1'b0);
        repeat (20) @(posedge pclk);
        chk("fault", {31'h0, link_fault_n}, 32'h0);
        apb(1'b0, A_IRQ, 32'h0);
        chk("stat0", rd & 32'h1, 32'h1);
        chk("irq_off", {31'h0, irq}, 32'h0);
        apb(1'b1, A_MASK, 32'h1);
        @(posedge pclk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        i_host.set_carrier(1'b1);
        repeat (20) @(posedge pclk);
        chk("fault_gone", {31'h0, link_fault_n}, 32'h1);
        apb(1'b1, A_IRQ, 32'h1);
        @(posedge pclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        serial_in_suitable <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("unsuitable", {31'h0, link_fault_n}, 32'h0);
        serial_in_suitable <= 1'b1;
        // Shortest legal pin reset, then a software reset of fixed length.
        apb(1'b1, A_IRQ, 32'hF);
        i_host.pulse_reset(1);
        @(posedge pclk);
        chk("pin_reset", {31'h0, logic_reset}, 32'h1);
        repeat (10) @(posedge pclk);
        chk("pin_rel", {31'h0, logic_reset}, 32'h0);
        apb(1'b0, A_IRQ, 32'h0);
        chk("done", rd & 32'h8, 32'h8);
        apb(1'b1, A_CTRL, 32'h3);
        cnt = 0;
        repeat (8)
        begin
            @(posedge pclk);
            if (logic_reset === 1'b1)
                cnt++;
        end
        chk("sw_len", 32'(cnt), 32'(link_ctrl_pkg::SW_RESET_CYCLES));
        apb(1'b0, A_CTRL, 32'h0);
        chk("ctrl_self", rd, 32'h2);
        finish_test();
    end
endmodule
`default_nettype wire
